// file: logic/adc_port_pkg.sv
package adc_port_pkg;
  localparam int NUM_CH = 8;
  localparam int RES_W = 16;
  localparam int ADDR_W = 7;
  localparam int REG_W = 8;
  localparam int SER_BITS = 16;
  localparam int CMD_BIT = 15;
  localparam int FIFO_DEPTH = 4;
  localparam logic [6:0] ADDR_EXIT = 7'h00;
  localparam logic [6:0] ADDR_PORT_CFG = 7'h02;
  localparam logic [6:0] ADDR_CRC_CTL = 7'h21;
  localparam int CFG_STATUS_BIT = 6;
  localparam int CFG_LINES_HI = 4;
  localparam int CFG_LINES_LO = 3;
  localparam int CRC_EN_BIT = 2;
  localparam logic [7:0] PORT_CFG_RST = 8'h00;
  localparam logic [7:0] CRC_CTL_RST = 8'h00;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;

  typedef enum logic [1:0] {
    LINES_ONE = 2'b00,
    LINES_TWO = 2'b01,
    LINES_FOUR = 2'b10,
    LINES_ONE_ALT = 2'b11
  } lines_e;

  typedef enum logic [1:0] {
    PROD_DATA = 2'b00,
    PROD_STATUS = 2'b01,
    PROD_CRC = 2'b10,
    PROD_DONE = 2'b11
  } prod_state_e;

  typedef struct packed {
    logic reset_seen;
    logic digital_fault;
    logic input_open;
    logic over_voltage_flag;
    logic under_voltage_flag;
    logic [2:0] channel_index;
  } status_hdr_s;

  typedef struct packed {
    logic first;
    logic [15:0] data;
  } par_word_s;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic sclk;
    logic port_type_select;
    logic software_mode;
    logic [15:0] db;
  } pins_s;
endpackage

// file: logic/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else if (flush) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: logic/adc_host_port.sv
`timescale 1ns/1ps
// What this block does
// (R01) result snapshot updates only on the busy falling edge
// (R02) host finishes a read during busy before busy falls
// (R03) software mode with crc enable appends a 16-bit crc after eight channels on the parallel bus only
// (R04) parallel crc covers every word on the bus, data, status and zeros
// (R05) status enable gives each channel a data frame then a status frame on the parallel bus only
// (R06) status frame: header on upper byte, lower byte zero
// (R07) header bits: reset, fault, open, over, under, channel index
// (R08) channel index is channel number minus one
// (R09) bus driven only while chip select and the read strobe are low
// (R10) read command in software mode: bit 15 high, address bits 14..8, enters register mode
// (R11) read address latched on write rise; next read returns 0, address, data
// (R12) write frame: bit 15 low, address, data; latched on write rise
// (R13) write to address 0 leaves register mode; no results in register mode
// (R14) host reads a register before writing a sequence
// (R15) config bits 4..3 pick one, two, four or one serial lines
// (R16) hardware mode uses two lines only
// (R17) chip select fall, or busy fall in 3-wire, presents the msb
// (R18) later bits shift on serial clock rise, 16 per channel
// (R19) chip select pulsed mid channel restarts that channel at msb
// (R20) one line needs 128 clocks, framed in 16s in software mode
// (R21) four lines move all eight results in 32 clocks
// (R22) serial marker: tri-state on cs high, set at start, cleared after 16th fall
// (R23) constant serial input issues no commands; results keep flowing
// (R24) parallel marker high on read delivering channel one, low on next read
// (R25) registers 8 bits on 7-bit address; unused addresses read zero
module adc_host_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic sclk,
  input wire logic port_type_select,
  input wire logic software_mode,
  input wire logic [15:0] parallel_data_bus_in,
  output logic [15:0] parallel_data_bus_out,
  output logic parallel_data_bus_oe,
  output logic serial_out_a,
  output logic serial_out_b,
  output logic serial_out_c,
  output logic serial_out_d,
  output logic [3:0] serial_out_oe,
  output logic first_channel_marker,
  output logic first_channel_marker_oe,
  input wire logic busy,
  input wire logic [7:0][15:0] conv_result,
  input wire logic reset_seen,
  input wire logic digital_fault,
  input wire logic [7:0] input_open,
  input wire logic [7:0] over_voltage_flag,
  input wire logic [7:0] under_voltage_flag,
  output logic register_mode
);
  function automatic logic [15:0] crc16_word(input logic [15:0] crc, input logic [15:0] word);
    logic [15:0] c;
    c = crc;
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ word[i]) ? ((c << 1) ^ adc_port_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
  function automatic logic [2:0] line_channel(input logic [1:0] lines, input int line,
                                              input logic [3:0] slot);
    logic [3:0] ch;
    ch = slot;
    if (lines == 2'(adc_port_pkg::LINES_TWO)) begin
      ch = 4'(line * 4) + slot;
    end else if (lines == 2'(adc_port_pkg::LINES_FOUR)) begin
      ch = 4'(line * 2) + slot;
    end
    return ch[2:0];
  endfunction
  // pin synchronisers
  adc_port_pkg::pins_s pins_raw;
  adc_port_pkg::pins_s sync1_q;
  adc_port_pkg::pins_s sync2_q;
  adc_port_pkg::pins_s prev_q;
  assign pins_raw = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, sclk: sclk,
                      port_type_select: port_type_select, software_mode: software_mode,
                      db: parallel_data_bus_in};
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
      sync2_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
      prev_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  logic busy_q;
  logic busy_fall;
  logic cs_fall;
  logic cs_rise;
  logic rd_fall;
  logic wr_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic sw_mode;
  logic par_mode;
  assign busy_fall = busy_q && !busy;
  assign cs_fall = prev_q.cs_n && !sync2_q.cs_n;
  assign cs_rise = !prev_q.cs_n && sync2_q.cs_n;
  assign rd_fall = prev_q.rd_n && !sync2_q.rd_n && !sync2_q.cs_n;
  assign wr_rise = !prev_q.wr_n && sync2_q.wr_n && !sync2_q.cs_n;
  assign sclk_rise = !prev_q.sclk && sync2_q.sclk;
  assign sclk_fall = prev_q.sclk && !sync2_q.sclk;
  assign sw_mode = sync2_q.software_mode;
  assign par_mode = !sync2_q.port_type_select;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy;
    end
  end

  // result and diagnostics snapshot
  logic [7:0][15:0] result_q;
  logic [7:0] open_q;
  logic [7:0] ov_q;
  logic [7:0] uv_q;
  logic reset_seen_q;
  logic fault_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      result_q <= '0;
      open_q <= '0;
      ov_q <= '0;
      uv_q <= '0;
      reset_seen_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (busy_fall) begin // [R01]
      result_q <= conv_result;
      open_q <= input_open;
      ov_q <= over_voltage_flag;
      uv_q <= under_voltage_flag;
      reset_seen_q <= reset_seen;
      fault_q <= digital_fault;
    end
  end

  // register file and command decode
  logic [7:0] port_cfg_q;
  logic [7:0] crc_ctl_q;
  logic [6:0] rd_addr_q;
  logic reg_mode_q;
  logic [7:0] reg_rdata;
  logic status_en;
  logic crc_en;
  logic [1:0] lines;
  assign status_en = sw_mode && port_cfg_q[adc_port_pkg::CFG_STATUS_BIT];
  assign crc_en = sw_mode && crc_ctl_q[adc_port_pkg::CRC_EN_BIT];
  assign register_mode = reg_mode_q;
  always_comb begin
    case (rd_addr_q) // [R25]
      adc_port_pkg::ADDR_PORT_CFG: reg_rdata = port_cfg_q;
      adc_port_pkg::ADDR_CRC_CTL: reg_rdata = crc_ctl_q;
      default: reg_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      port_cfg_q <= adc_port_pkg::PORT_CFG_RST;
      crc_ctl_q <= adc_port_pkg::CRC_CTL_RST;
      rd_addr_q <= '0;
      reg_mode_q <= 1'b0;
    end else if (!sw_mode) begin
      reg_mode_q <= 1'b0;
    end else if (wr_rise && par_mode) begin
      if (sync2_q.db[adc_port_pkg::CMD_BIT]) begin
        rd_addr_q <= sync2_q.db[14:8]; // [R10] [R11]
        reg_mode_q <= 1'b1;
      end else if (sync2_q.db[14:8] == adc_port_pkg::ADDR_EXIT) begin
        reg_mode_q <= 1'b0; // [R13]
      end else if (sync2_q.db[14:8] == adc_port_pkg::ADDR_PORT_CFG) begin
        port_cfg_q <= sync2_q.db[7:0]; // [R12]
      end else if (sync2_q.db[14:8] == adc_port_pkg::ADDR_CRC_CTL) begin
        crc_ctl_q <= sync2_q.db[7:0]; // [R12]
      end
    end
  end

  // parallel word producer
  adc_port_pkg::prod_state_e state_q;
  logic [2:0] ch_q;
  logic [15:0] crc_q;
  adc_port_pkg::par_word_s prod_word;
  adc_port_pkg::status_hdr_s hdr;
  logic prod_valid;
  logic prod_ready;
  logic push;
  logic last_ch;
  assign hdr = '{reset_seen: reset_seen_q, digital_fault: fault_q, input_open: open_q[ch_q],
                 over_voltage_flag: ov_q[ch_q], under_voltage_flag: uv_q[ch_q],
                 channel_index: ch_q}; // [R07] [R08]
  assign prod_valid = (state_q != adc_port_pkg::PROD_DONE);
  assign push = prod_valid && prod_ready;
  assign last_ch = (ch_q == 3'(adc_port_pkg::NUM_CH - 1));
  always_comb begin
    case (state_q)
      adc_port_pkg::PROD_DATA: prod_word = '{first: (ch_q == 3'h0), data: result_q[ch_q]};
      adc_port_pkg::PROD_STATUS: prod_word = '{first: 1'b0, data: {hdr, 8'h00}}; // [R06]
      adc_port_pkg::PROD_CRC: prod_word = '{first: 1'b0, data: crc_q};
      default: prod_word = '0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= adc_port_pkg::PROD_DONE;
      ch_q <= '0;
      crc_q <= adc_port_pkg::CRC_INIT;
    end else if (busy_fall) begin
      state_q <= adc_port_pkg::PROD_DATA;
      ch_q <= '0;
      crc_q <= adc_port_pkg::CRC_INIT;
    end else if (push) begin
      crc_q <= crc16_word(crc_q, prod_word.data); // [R04]
      case (state_q)
        adc_port_pkg::PROD_DATA: begin
          if (status_en) begin
            state_q <= adc_port_pkg::PROD_STATUS; // [R05]
          end else if (last_ch) begin
            state_q <= crc_en ? adc_port_pkg::PROD_CRC : adc_port_pkg::PROD_DONE;
          end else begin
            ch_q <= ch_q + 3'h1;
          end
        end
        adc_port_pkg::PROD_STATUS: begin
          if (last_ch) begin
            state_q <= crc_en ? adc_port_pkg::PROD_CRC : adc_port_pkg::PROD_DONE; // [R03]
          end else begin
            state_q <= adc_port_pkg::PROD_DATA;
            ch_q <= ch_q + 3'h1;
          end
        end
        default: state_q <= adc_port_pkg::PROD_DONE;
      endcase
    end
  end

  adc_port_pkg::par_word_s fifo_word;
  logic fifo_valid;
  logic pop;
  assign pop = rd_fall && par_mode && !reg_mode_q && fifo_valid; // [R13]
  word_fifo #(
    .WIDTH($bits(adc_port_pkg::par_word_s)),
    .DEPTH(adc_port_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .flush(busy_fall),
    .in_valid(prod_valid),
    .in_ready(prod_ready),
    .in_data(prod_word),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_word)
  );

  // parallel output
  logic [15:0] db_out_q;
  logic par_marker_q;
  assign parallel_data_bus_out = db_out_q;
  assign parallel_data_bus_oe = par_mode && !sync2_q.cs_n && !sync2_q.rd_n; // [R09]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      db_out_q <= '0;
      par_marker_q <= 1'b0;
    end else if (rd_fall && par_mode) begin
      if (reg_mode_q) begin
        db_out_q <= {1'b0, rd_addr_q, reg_rdata}; // [R11]
        par_marker_q <= 1'b0;
      end else if (fifo_valid) begin
        db_out_q <= fifo_word.data;
        par_marker_q <= fifo_word.first; // [R24]
      end else begin
        par_marker_q <= 1'b0;
      end
    end
  end

  // serial readout; serial input is never decoded here
  logic [3:0] bit_q;
  logic [3:0] slot_q;
  logic ser_marker_q;
  logic [3:0] sout_q;
  logic [3:0] per_line;
  logic [3:0] line_en;
  always_comb begin
    lines = port_cfg_q[adc_port_pkg::CFG_LINES_HI:adc_port_pkg::CFG_LINES_LO]; // [R15]
    if (!sw_mode) begin
      lines = 2'(adc_port_pkg::LINES_TWO); // [R16]
    end
    case (lines)
      2'(adc_port_pkg::LINES_TWO): begin
        per_line = 4'h4;
        line_en = 4'h3;
      end
      2'(adc_port_pkg::LINES_FOUR): begin
        per_line = 4'h2; // [R21]
        line_en = 4'hf;
      end
      default: begin
        per_line = 4'h8; // [R20]
        line_en = 4'h1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bit_q <= '0;
      slot_q <= '0;
    end else if (busy_fall) begin
      bit_q <= '0;
      slot_q <= '0;
    end else if (cs_rise && bit_q != 4'h0) begin
      bit_q <= '0; // [R19]
    end else if (sclk_rise && !sync2_q.cs_n) begin
      bit_q <= bit_q + 4'h1; // [R18]
      if (bit_q == 4'(adc_port_pkg::SER_BITS - 1)) begin
        slot_q <= slot_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sout_q <= '0;
    end else begin
      for (int l = 0; l < 4; l++) begin
        if (line_en[l] && slot_q < per_line && !reg_mode_q) begin
          sout_q[l] <= result_q[line_channel(lines, l, slot_q)][4'hf - bit_q]; // [R17] [R23]
        end else begin
          sout_q[l] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ser_marker_q <= 1'b0;
    end else if (busy_fall) begin
      ser_marker_q <= !sync2_q.cs_n; // [R22]
    end else if (cs_fall) begin
      ser_marker_q <= !busy && slot_q == 4'h0 && bit_q == 4'h0; // [R22]
    end else if (sclk_fall && slot_q != 4'h0) begin
      ser_marker_q <= 1'b0; // [R22]
    end
  end

  assign serial_out_a = sout_q[0];
  assign serial_out_b = sout_q[1];
  assign serial_out_c = sout_q[2];
  assign serial_out_d = sout_q[3];
  assign serial_out_oe = (!par_mode && !sync2_q.cs_n) ? line_en : 4'h0;
  assign first_channel_marker = par_mode ? par_marker_q : ser_marker_q;
  assign first_channel_marker_oe = !sync2_q.cs_n;
endmodule

// file: verif/port_monitor.sv
`timescale 1ns/1ps
module port_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic port_type_select,
  input wire logic software_mode,
  input wire logic [15:0] parallel_data_bus_in,
  input wire logic [15:0] parallel_data_bus_out,
  input wire logic parallel_data_bus_oe,
  input wire logic [3:0] serial_out_oe,
  input wire logic first_channel_marker_oe,
  input wire logic register_mode
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic [3:0] wr_hi_q;
  logic [3:0] rd_age_q;
  logic [2:0] hw_q;
  // cycles since write strobe low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) wr_hi_q <= 4'h0;
    else wr_hi_q <= !wr_n ? 4'h0 : wr_hi_q + {3'h0, wr_hi_q != 4'hf};
  end
  // cycles since read strobe fell
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) rd_age_q <= 4'hf;
    else rd_age_q <= $fell(rd_n) ? 4'h0 : rd_age_q + {3'h0, rd_age_q != 4'hf};
  end
  // cycles in hardware mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) hw_q <= 3'h0;
    else hw_q <= software_mode ? 3'h0 : hw_q + {2'h0, hw_q != 3'h7};
  end
  sequence s_cmd_taken;
    $rose(wr_n) && !cs_n && software_mode && !port_type_select;
  endsequence
  sequence s_reg_rd;
    register_mode && !cs_n && $fell(rd_n);
  endsequence
  a_bus_drive_gate: assert property (
    parallel_data_bus_oe |-> !$past(cs_n, 2) && !$past(rd_n, 2))
    else $error("bus driven outside a read");
  a_bus_drive_on: assert property (
    (!cs_n && !rd_n && !port_type_select)[*4] |-> parallel_data_bus_oe)
    else $error("bus not driven during a read");
  a_marker_tristate: assert property (
    first_channel_marker_oe |-> !$past(cs_n, 2)) else $error("marker driven while deselected");
  a_reg_read_format: assert property (
    s_reg_rd |-> ##4 !parallel_data_bus_out[15]) else $error("register word top bit set");
  a_regmode_entry: assert property (
    s_cmd_taken ##0 parallel_data_bus_in[15] |-> ##[1:6] register_mode)
    else $error("read command did not enter register mode");
  a_regmode_exit: assert property (
    s_cmd_taken ##0 parallel_data_bus_in[15:8] == 8'h00 |-> ##[1:6] !register_mode)
    else $error("write to zero did not leave register mode");
  a_regmode_steady: assert property (
    wr_hi_q == 4'hf |=> $stable(register_mode)) else $error("mode moved without a write");
  a_hw_two_lines: assert property (
    hw_q == 3'h7 |-> serial_out_oe[3:2] == 2'b00) else $error("extra lines in hardware mode");
  a_hw_line_pair: assert property (
    hw_q == 3'h7 && !$past(cs_n, 2) && $past(port_type_select, 2) |-> serial_out_oe == 4'h3)
    else $error("hardware mode not on two lines");
  a_bus_word_hold: assert property (
    !$stable(parallel_data_bus_out) |-> rd_age_q inside {[4'h1:4'h8]})
    else $error("bus word changed without a read");
endmodule

bind adc_host_port port_monitor i_port_monitor (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n),
  .rd_n(rd_n), .wr_n(wr_n), .port_type_select(port_type_select),
  .software_mode(software_mode), .parallel_data_bus_in(parallel_data_bus_in),
  .parallel_data_bus_out(parallel_data_bus_out), .parallel_data_bus_oe(parallel_data_bus_oe),
  .serial_out_oe(serial_out_oe), .first_channel_marker_oe(first_channel_marker_oe),
  .register_mode(register_mode));

// file: verif/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic clk_sys,
  input wire logic [15:0] bus_out,
  input wire logic [3:0] ser_out,
  input wire logic marker,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic sclk,
  output logic [15:0] db,
  output logic got_valid,
  output logic [16:0] got_word
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    sclk = 1'b0;
    db = 16'h5a5a;
    got_valid = 1'b0;
    got_word = 17'h0_0000;
  end
  task automatic gap();
    repeat (10) @(negedge clk_sys);
  endtask
  // chip select parked low across busy fall, 3-wire
  task automatic hold_cs();
    @(negedge clk_sys);
    cs_n = 1'b0;
  endtask
  task automatic emit(input logic [16:0] w);
    @(negedge clk_sys);
    got_word = w;
    got_valid = 1'b1;
    @(negedge clk_sys);
    got_valid = 1'b0;
  endtask
  // frame held across the write rise, bus inverted after chip select rises
  task automatic par_write(input logic [15:0] w);
    @(negedge clk_sys);
    cs_n = 1'b0;
    wr_n = 1'b0;
    db = w;
    gap();
    wr_n = 1'b1;
    gap();
    cs_n = 1'b1;
    db = ~w;
    gap();
  endtask
  task automatic par_read();
    @(negedge clk_sys);
    cs_n = 1'b0;
    rd_n = 1'b0;
    gap();
    emit({marker, bus_out});
    rd_n = 1'b1;
    cs_n = 1'b1;
    gap();
  endtask
  // bits taken before each rise; short frames are dropped
  task automatic ser_read(input int nw, input int nl, input int nb);
    logic [3:0][15:0] sh;
    logic mk;
    @(negedge clk_sys);
    cs_n = 1'b0;
    gap();
    for (int w = 0; w < nw; w++) begin
      #40 mk = marker;
      for (int b = 0; b < nb; b++) begin
        for (int l = 0; l < 4; l++) sh[l][15 - b] = ser_out[l];
        #62.5 sclk = 1'b1;
        #62.5 sclk = 1'b0;
      end
      for (int l = 0; l < nl && nb == 16; l++) emit({mk && l == 0, sh[l]});
    end
    @(negedge clk_sys);
    cs_n = 1'b1;
    gap();
  endtask
endmodule

// file: verif/adc_host_port_bench.sv
`timescale 1ns/1ps
module adc_host_port_bench;
  logic clk_sys, rst, cs_n, rd_n, wr_n, sclk, port_type_select, software_mode;
  logic [15:0] db, bus_out;
  logic bus_oe, mark, mark_oe, busy, reset_seen, digital_fault, register_mode, got_valid;
  logic [3:0] ser;
  logic [7:0][15:0] conv_result;
  logic [7:0] input_open, over_voltage_flag, under_voltage_flag;
  logic [16:0] got_word;
  logic [16:0] exp_q[$];
  logic [31:0] seed;
  int n_mismatch, samples_checked;
  adc_host_port i_adc_host_port (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .sclk(sclk), .port_type_select(port_type_select),
    .software_mode(software_mode), .parallel_data_bus_in(db), .parallel_data_bus_out(bus_out),
    .parallel_data_bus_oe(bus_oe), .serial_out_a(ser[0]), .serial_out_b(ser[1]),
    .serial_out_c(ser[2]), .serial_out_d(ser[3]), .serial_out_oe(),
    .first_channel_marker(mark), .first_channel_marker_oe(mark_oe), .busy(busy),
    .conv_result(conv_result), .reset_seen(reset_seen), .digital_fault(digital_fault),
    .input_open(input_open), .over_voltage_flag(over_voltage_flag),
    .under_voltage_flag(under_voltage_flag), .register_mode(register_mode));
  host_model i_host_model (.clk_sys(clk_sys), .bus_out(bus_oe ? bus_out : 16'hxxxx),
    .ser_out(ser), .marker(mark_oe ? mark : 1'bx), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .sclk(sclk), .db(db), .got_valid(got_valid), .got_word(got_word));
  always #2 clk_sys = ~clk_sys;
  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? adc_port_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction
  always @(posedge clk_sys) begin
    if (got_valid === 1'b1)
      check("read word", got_word, exp_q.size() != 0 ? exp_q.pop_front() : 17'hx_xxxx);
  end
  // new results land while busy, taken at its fall; reads only follow it
  task automatic convert();
    @(negedge clk_sys);
    busy = 1'b1;
    for (int c = 0; c < 8; c++) begin
      seed = xs(seed);
      conv_result[c] = seed[15:0];
      input_open[c] = seed[16];
      over_voltage_flag[c] = seed[17];
      under_voltage_flag[c] = seed[18];
    end
    reset_seen = seed[19];
    digital_fault = seed[20];
    repeat (8) @(negedge clk_sys);
    busy = 1'b0;
    repeat (20) @(negedge clk_sys);
  endtask
  task automatic expect_par(input logic stat, input logic crc);
    logic [15:0] c;
    logic [15:0] w;
    c = adc_port_pkg::CRC_INIT;
    for (int ch = 0; ch < 8; ch++) begin
      exp_q.push_back({ch == 0, conv_result[ch]});
      c = crc16(c, conv_result[ch]);
      w = {reset_seen, digital_fault, input_open[ch], over_voltage_flag[ch],
        under_voltage_flag[ch], 3'(ch), 8'h00};
      if (stat) exp_q.push_back({1'b0, w});
      if (stat) c = crc16(c, w);
    end
    if (crc) exp_q.push_back({1'b0, c});
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] d);
    i_host_model.par_write({1'b1, a, 8'h00});
    exp_q.push_back({2'b00, a, d});
    i_host_model.par_read();
  endtask
  task automatic ser_phase(input int n, input logic abort);
    port_type_select = 1'b1;
    if (!software_mode) i_host_model.hold_cs();
    convert();
    if (abort) i_host_model.ser_read(1, 1, 5);
    for (int w = 0; w < 8 / n; w++)
      for (int l = 0; l < n; l++)
        exp_q.push_back({w == 0 && l == 0, conv_result[l * (8 / n) + w]});
    i_host_model.ser_read(8 / n, n, 16);
  endtask
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    busy = 1'b0;
    port_type_select = 1'b0;
    software_mode = 1'b0;
    conv_result = '0;
    reset_seen = 1'b0;
    digital_fault = 1'b0;
    input_open = 8'h00;
    over_voltage_flag = 8'h00;
    under_voltage_flag = 8'h00;
    seed = 32'h0000_0039;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (5) @(negedge clk_sys);
    check("register mode", {16'h0000, register_mode}, 17'h0_0000);
    i_host_model.par_write({1'b1, adc_port_pkg::ADDR_PORT_CFG, 8'h00});
    check("register mode", {16'h0000, register_mode}, 17'h0_0000);
    convert();
    expect_par(1'b0, 1'b0);
    repeat (8) i_host_model.par_read();
    software_mode = 1'b1;
    read_reg(adc_port_pkg::ADDR_PORT_CFG, adc_port_pkg::PORT_CFG_RST);
    check("register mode", {16'h0000, register_mode}, 17'h0_0001);
    i_host_model.par_write({1'b0, adc_port_pkg::ADDR_PORT_CFG, 8'h40});
    i_host_model.par_write({1'b0, adc_port_pkg::ADDR_CRC_CTL, 8'h04});
    read_reg(adc_port_pkg::ADDR_PORT_CFG, 8'h40);
    read_reg(adc_port_pkg::ADDR_CRC_CTL, 8'h04);
    read_reg(7'h55, 8'h00);
    i_host_model.par_write({1'b0, adc_port_pkg::ADDR_EXIT, 8'h00});
    check("register mode", {16'h0000, register_mode}, 17'h0_0000);
    convert();
    expect_par(1'b1, 1'b1);
    repeat (17) i_host_model.par_read();
    // line codes one, two, four, one
    for (int k = 0; k < 4; k++) begin
      port_type_select = 1'b0;
      i_host_model.par_write({1'b0, adc_port_pkg::ADDR_PORT_CFG, 3'h0, 2'(k), 3'h0});
      ser_phase(k == 1 ? 2 : k == 2 ? 4 : 1, k == 0);
    end
    software_mode = 1'b0;
    ser_phase(2, 1'b0);
    for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge clk_sys);
    if (exp_q.size() != 0) n_mismatch++;
    finish_test();
  end
endmodule
